// >>> hdl/ttsf_formatter.sv
// teletext line formatter: records into queue, host port, interrupts
// assumes slicer and host port are logic on core_clk, no synchronisers
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module ttsf_formatter
	import ttsf_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH,
	parameter int AW    = QUEUE_AW
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// parallel host port
	input  wire logic [1:0] hostAddr,
	input  wire logic [7:0] hostWrData,
	input  wire logic       hostWrStb,
	input  wire logic       hostRdStb,
	output logic      [7:0] hostRdData,
	output logic            irq,
	// sliced line from the slicer
	input  wire logic       lineStart,
	input  wire logic [8:0] lineNum,
	input  wire logic       fmtBasic,
	input  wire logic       sys625,
	input  wire logic       hamErr,
	input  wire logic       parErr,
	input  wire logic       hdrErr,
	input  wire logic       match1,
	input  wire logic       match2,
	input  wire logic       payloadValid,
	input  wire logic [7:0] payloadByte,
	input  wire logic       lineEnd,
	input  wire logic       fieldEnd,
	// closed caption
	input  wire logic       ccValid,
	input  wire logic [7:0] ccByte0,
	input  wire logic [7:0] ccByte1,
	// ancillary data stream
	input  wire logic       ancReady,
	output logic            ancValid,
	output logic      [7:0] ancByte
);

	// -----------------------------------------------
	// declarations
	// -----------------------------------------------
	ttsf_state_t     state_q;
	logic [2:0]      ctrl_q;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] status_d;
	logic [ST_W-1:0] stEvent;
	logic [ST_W-1:0] stClear;
	logic [7:0]      index_q;
	logic [7:0]      ccLo_q;
	logic [7:0]      ccHi_q;
	logic [7:0]      hostRdData_q;
	logic            irq_q;
	logic            ancValid_q;
	logic [7:0]      ancByte_q;
	logic [7:0]      statByte_q;
	logic            basic_q;
	logic            is625_q;
	logic [5:0]      bodyCnt_q;
	logic [5:0]      recLen;
	logic            push;
	logic [8:0]      pushData;
	logic            pop1;
	logic            pop2;
	logic [8:0]      headData;
	logic [8:0]      nextData;
	logic [AW:0]     count;
	logic            empty;
	logic            headPad;
	logic            room;
	logic            accept;
	logic            queueRd;
	logic            ancTake;
	logic [7:0]      rdByte;
	logic [7:0]      statByte;
	logic [7:0]      indData;

	// -----------------------------------------------
	// queue
	// -----------------------------------------------
	ttsf_line_fifo #(
		.W    (9),
		.DEPTH(DEPTH),
		.AW   (AW)
	) u_queue (
		.core_clk(core_clk),
		.reset   (reset),
		.push    (push),
		.pushData(pushData),
		.pop1    (pop1),
		.pop2    (pop2),
		.headData(headData),
		.nextData(nextData),
		.count   (count)
	);

	assign empty   = (count == '0);
	assign headPad = headData[8];
	// a new line needs room for the longest record
	assign room    = (count <= (AW+1)'(DEPTH) - (AW+1)'(LEN_WST625));
	assign accept  = lineStart && ctrl_q[CTRL_TTX] && (state_q == S_IDLE);
	assign queueRd = hostRdStb && (hostAddr == HP_QUEUE) && !ctrl_q[CTRL_ANC];
	assign ancTake = ctrl_q[CTRL_ANC] && ancReady && !empty && !headPad;

	// record length from the latched format
	assign recLen = basic_q ? LEN_BASIC : (is625_q ? LEN_WST625 : LEN_WST525);

	// status byte with error and match flags
	always_comb begin
		statByte              = 8'h00;
		statByte[SB_LINE8]    = lineNum[8];
		statByte[SB_MATCH1]   = match1;
		statByte[SB_MATCH2]   = match2;
		statByte[SB_HDRCHK]   = fmtBasic && hdrErr;
		statByte[SB_PARITY]   = parErr;
		statByte[SB_HAMMING]  = hamErr;
	end

	// -----------------------------------------------
	// record writer
	// -----------------------------------------------
	// byte to push in each phase of a record
	always_comb begin
		push     = 1'b0;
		pushData = 9'h000;
		case (state_q)
			S_IDLE: begin
				if (accept && room) begin
					push     = 1'b1;
					pushData = {1'b0, lineNum[7:0]};
				end
			end
			S_STATUS: begin
				push     = 1'b1;
				pushData = {1'b0, statByte_q};
			end
			S_BODY: begin
				if (lineEnd) begin
					push     = bodyCnt_q[0];
					pushData = {1'b1, PAD_BYTE};
				end else if (payloadValid && (bodyCnt_q < recLen)) begin
					push     = 1'b1;
					pushData = {1'b0, payloadByte};
				end
			end
			default: begin
				push     = 1'b0;
				pushData = 9'h000;
			end
		endcase
	end

	// phase sequencing and line attributes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q    <= S_IDLE;
			basic_q    <= 1'b1;
			is625_q    <= 1'b0;
			statByte_q <= 8'h00;
			bodyCnt_q  <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (accept && room) begin
						state_q    <= S_STATUS;
						basic_q    <= fmtBasic;
						is625_q    <= sys625;
						statByte_q <= statByte;
					end
				end
				S_STATUS: begin
					state_q   <= S_BODY;
					bodyCnt_q <= LEN_HDR;
				end
				S_BODY: begin
					if (lineEnd) begin
						state_q <= S_IDLE;
					end else if (push) begin
						bodyCnt_q <= bodyCnt_q + LEN_ONE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------
	// reader with pad skipping
	// -----------------------------------------------
	// host read steps over a pad at the head; idle pads are dropped
	always_comb begin
		pop1   = 1'b0;
		pop2   = 1'b0;
		rdByte = 8'h00;
		if (queueRd && !empty) begin
			if (!headPad) begin
				rdByte = headData[7:0];
				pop1   = 1'b1;
			end else if (count > (AW+1)'(1)) begin
				rdByte = nextData[7:0];
				pop2   = 1'b1;
			end else begin
				pop1 = 1'b1;
			end
		end else if (ancTake || (!empty && headPad)) begin
			pop1 = 1'b1;
		end
	end

	// ancillary byte stream output
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ancValid_q <= 1'b0;
			ancByte_q  <= 8'h00;
		end else begin
			ancValid_q <= ancTake;
			ancByte_q  <= ancTake ? headData[7:0] : 8'h00;
		end
	end

	// -----------------------------------------------
	// host registers
	// -----------------------------------------------
	// control, mask and indirect index writes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			index_q <= 8'h00;
			ctrl_q  <= CTRL_RESET;
			mask_q  <= '0;
		end else if (hostWrStb) begin
			if (hostAddr == HP_INDEX) begin
				index_q <= hostWrData;
			end else if (hostAddr == HP_DATA && index_q == IX_CTRL) begin
				ctrl_q <= hostWrData[2:0];
			end else if (hostAddr == HP_DATA && index_q == IX_MASK) begin
				mask_q <= hostWrData[ST_W-1:0];
			end
		end
	end

	// closed caption pair held apart from the queue
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ccLo_q <= 8'h00;
			ccHi_q <= 8'h00;
		end else if (ccValid && ctrl_q[CTRL_CC]) begin
			ccLo_q <= ccByte0;
			ccHi_q <= ccByte1;
		end
	end

	// sticky events; a set in the clearing cycle survives
	always_comb begin
		stEvent           = '0;
		stEvent[ST_LINE]  = (state_q == S_BODY) && lineEnd;
		stEvent[ST_FIELD] = fieldEnd;
		stEvent[ST_OVF]   = accept && !room;
		stEvent[ST_CC]    = ccValid && ctrl_q[CTRL_CC];
		stClear           = (hostWrStb && hostAddr == HP_STATUS) ? hostWrData[ST_W-1:0] : '0;
		status_d          = (status_q & ~stClear) | stEvent;
	end

	// status and interrupt line
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			status_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q    <= |(status_d & mask_q);
		end
	end

	// indirect read selection
	always_comb begin
		case (index_q)
			IX_CTRL:  indData = {5'h00, ctrl_q};
			IX_MASK:  indData = {{(8-ST_W){1'b0}}, mask_q};
			IX_CC_LO: indData = ccLo_q;
			IX_CC_HI: indData = ccHi_q;
			default:  indData = 8'h00;
		endcase
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hostRdData_q <= 8'h00;
		end else if (!hostRdStb) begin
			hostRdData_q <= 8'h00;
		end else begin
			case (hostAddr)
				HP_INDEX:  hostRdData_q <= index_q;
				HP_DATA:   hostRdData_q <= indData;
				HP_QUEUE:  hostRdData_q <= rdByte;
				HP_STATUS: hostRdData_q <= {{(8-ST_W){1'b0}}, status_q};
				default:   hostRdData_q <= 8'h00;
			endcase
		end
	end

	assign hostRdData = hostRdData_q;
	assign irq        = irq_q;
	assign ancValid   = ancValid_q;
	assign ancByte    = ancByte_q;

	// -----------------------------------------------
	// checks
	// -----------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_line_header: assert property (accept && room |-> push && pushData == {1'b0, lineNum[7:0]})
		else $error("line low byte not written first");
	a_status_next: assert property (state_q == S_STATUS |-> push && !pushData[8])
		else $error("status byte missing after line byte");
	a_world_bit3: assert property (state_q == S_STATUS && !basic_q |-> !pushData[SB_HDRCHK])
		else $error("header check bit set in world record");
	a_body_order: assert property (state_q == S_BODY && push && !lineEnd |-> pushData == {1'b0, payloadByte})
		else $error("body byte out of order");
	a_even_record: assert property (state_q == S_BODY && lineEnd |-> (bodyCnt_q[0] == push))
		else $error("record not padded to even length");
	a_pad_hidden: assert property (queueRd && headPad && count > (AW+1)'(1) |=> hostRdData == $past(nextData[7:0]))
		else $error("pad byte shown to host");
	a_length_cap: assert property (state_q == S_BODY |-> bodyCnt_q <= recLen)
		else $error("record longer than its format");
	a_room_kept: assert property (lineStart && ctrl_q[CTRL_TTX] && state_q == S_IDLE && room |=> state_q == S_STATUS)
		else $error("line dropped with room in queue");
	a_irq_level: assert property (##1 irq == |($past(status_d) & $past(mask_q)))
		else $error("interrupt does not follow masked status");
	a_cc_store: assert property (ccValid && ctrl_q[CTRL_CC] |=> ccLo_q == $past(ccByte0) && status_q[ST_CC])
		else $error("caption bytes not held");
	a_anc_path: assert property (ancTake |=> ancValid && ancByte == $past(headData[7:0]))
		else $error("ancillary byte lost");

endmodule

// >>> hdl/ttsf_pkg.sv
// constants for the teletext slice queue formatter
// assumes one core clock; slicer and host port logic share it
// Behaviour
// - slice, parse, error-check VBI or active teletext (done by the slicer; this core only queues its error flags)
// - support basic and world system formats
// - queue holds 14 basic or 525-line world records, or 11 world 625-line records
// - records go to host or ancillary output
// - configurable interrupts for whole-field collection
// - closed-caption bytes in separate host register
// - line low byte, then error status byte
// - world format forces header check bit zero
// - body bytes keep slicer order after header
// - pad to even length, reader skips pad
package ttsf_pkg;

	// -----------------------------------------------
	// host port addresses and indirect indexes
	// -----------------------------------------------
	localparam logic [1:0] HP_INDEX  = 2'h0;
	localparam logic [1:0] HP_DATA   = 2'h1;
	localparam logic [1:0] HP_QUEUE  = 2'h2;
	localparam logic [1:0] HP_STATUS = 2'h3;
	localparam logic [7:0] IX_CTRL   = 8'h00;
	localparam logic [7:0] IX_MASK   = 8'h01;
	localparam logic [7:0] IX_CC_LO  = 8'h02;
	localparam logic [7:0] IX_CC_HI  = 8'h03;

	// -----------------------------------------------
	// control and status fields
	// -----------------------------------------------
	localparam int         CTRL_TTX   = 0;
	localparam int         CTRL_CC    = 1;
	localparam int         CTRL_ANC   = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	localparam int         ST_W       = 4;
	localparam int         ST_LINE    = 0;
	localparam int         ST_FIELD   = 1;
	localparam int         ST_OVF     = 2;
	localparam int         ST_CC      = 3;

	// -----------------------------------------------
	// record layout
	// -----------------------------------------------
	localparam int         SB_LINE8    = 0;
	localparam int         SB_MATCH1   = 1;
	localparam int         SB_MATCH2   = 2;
	localparam int         SB_HDRCHK   = 3;
	localparam int         SB_PARITY   = 4;
	localparam int         SB_HAMMING  = 5;
	localparam logic [5:0] LEN_HDR     = 6'h02;
	localparam logic [5:0] LEN_BASIC   = 6'h23;
	localparam logic [5:0] LEN_WST525  = 6'h24;
	localparam logic [5:0] LEN_WST625  = 6'h2c;
	localparam logic [5:0] LEN_ONE     = 6'h01;
	localparam logic [7:0] PAD_BYTE    = 8'h00;
	localparam int         QUEUE_DEPTH = 512;
	localparam int         QUEUE_AW    = 9;

	typedef enum logic [1:0] {S_IDLE, S_STATUS, S_BODY} ttsf_state_t;

endpackage

// >>> hdl/ttsf_line_fifo.sv
// byte queue with a pad marker bit per entry
// assumes DEPTH is a power of two and pops never exceed count
`timescale 1ns/1ps
module ttsf_line_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          reset,
	// write side
	input  wire logic          push,
	input  wire logic [W-1:0]  pushData,
	// read side
	input  wire logic          pop1,
	input  wire logic          pop2,
	output logic      [W-1:0]  headData,
	output logic      [W-1:0]  nextData,
	output logic      [AW:0]   count
);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0]   count_q;
	logic [AW:0]   popN;

	// number of entries leaving this cycle
	assign popN = pop2 ? (AW+1)'(2) : (pop1 ? (AW+1)'(1) : '0);

	// storage, no reset needed
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_q] <= pushData;
		end
	end

	// pointers and fill level
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + AW'(1);
			end
			rdPtr_q <= rdPtr_q + popN[AW-1:0];
			count_q <= count_q + (AW+1)'(push) - popN;
		end
	end

	// two look-ahead ports so a pad can be stepped over
	assign headData = mem[rdPtr_q];
	assign nextData = mem[rdPtr_q + AW'(1)];
	assign count    = count_q;

endmodule

// >>> test/ttsf_host_model.sv
// host processor model on the parallel host port
// assumes reads answer in the cycle after the strobe and writes never wait
`timescale 1ns/1ps
module ttsf_host_model (
	// clock
	input  wire logic       core_clk,
	// parallel host port
	output logic      [1:0] hostAddr,
	output logic      [7:0] hostWrData,
	output logic            hostWrStb,
	output logic            hostRdStb,
	input  wire logic [7:0] hostRdData
);
	// high while a held read leaves the strobe up for the next read
	logic chained = 1'b0;

	// idle bus at time zero
	initial begin
		hostAddr   = 2'h0;
		hostWrData = 8'h00;
		hostWrStb  = 1'b0;
		hostRdStb  = 1'b0;
	end

	// one write cycle; released lines are inverted so stale values never match
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		hostAddr   <= a;
		hostWrData <= d;
		hostWrStb  <= 1'b1;
		@(posedge core_clk);
		hostWrStb  <= 1'b0;
		hostAddr   <= ~a;
		hostWrData <= ~d;
	endtask

	// single read cycle per byte, data taken once settled after the read edge
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		if (!chained) @(posedge core_clk);
		hostAddr  <= a;
		hostRdStb <= 1'b1;
		@(posedge core_clk);
		hostRdStb <= 1'b0;
		hostAddr  <= ~a;
		chained = 1'b0;
		#1;
		d = hostRdData;
	endtask

	// read that keeps the strobe up so the next read follows with no gap
	task automatic rdHeld(input logic [1:0] a, output logic [7:0] d);
		if (!chained) @(posedge core_clk);
		hostAddr  <= a;
		hostRdStb <= 1'b1;
		@(posedge core_clk);
		chained = 1'b1;
		#1;
		d = hostRdData;
	endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the teletext line formatter
// assumes one 100 MHz core clock; the host model owns the register port
`timescale 1ns/1ps
module testbench
	import ttsf_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       reset    = 1'b1;
	logic [1:0] hostAddr;
	logic [7:0] hostWrData, hostRdData, ancByte, payloadByte = 8'h00, ccByte0 = 8'h00, ccByte1 = 8'h00;
	logic       hostWrStb, hostRdStb, irq, ancValid, ancReady = 1'b0;
	logic       lineStart = 1'b0, fmtBasic = 1'b0, sys625 = 1'b0, payloadValid = 1'b0, lineEnd = 1'b0;
	logic       hamErr = 1'b0, parErr = 1'b0, hdrErr = 1'b0, match1 = 1'b0, match2 = 1'b0;
	logic       fieldEnd = 1'b0, ccValid = 1'b0;
	logic [8:0] lineNum = 9'h000;
	logic [7:0] expQ[$], ancQ[$];
	int         errorCnt = 0, checksDone = 0;
	integer     seed = 32'h7265edd0;

	// -----------------------------------------------
	// clock, parts and monitors
	// -----------------------------------------------
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) ancReady <= 1'($random(seed)); // sink stalls at random
	always @(negedge core_clk) if (ancValid === 1'b1) ancQ.push_back(ancByte);

	ttsf_host_model i_host (.core_clk(core_clk), .hostAddr(hostAddr), .hostWrData(hostWrData),
		.hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostRdData(hostRdData));
	ttsf_formatter i_dut (.core_clk(core_clk), .reset(reset), .hostAddr(hostAddr), .hostWrData(hostWrData),
		.hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostRdData(hostRdData), .irq(irq),
		.lineStart(lineStart), .lineNum(lineNum), .fmtBasic(fmtBasic), .sys625(sys625), .hamErr(hamErr),
		.parErr(parErr), .hdrErr(hdrErr), .match1(match1), .match2(match2), .payloadValid(payloadValid),
		.payloadByte(payloadByte), .lineEnd(lineEnd), .fieldEnd(fieldEnd), .ccValid(ccValid),
		.ccByte0(ccByte0), .ccByte1(ccByte1), .ancReady(ancReady), .ancValid(ancValid), .ancByte(ancByte));

	// -----------------------------------------------
	// expectations and helpers
	// -----------------------------------------------
	function automatic int recLen(input logic b, input logic s);
		return b ? 35 : (s ? 44 : 36);
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] want);
		checksDone++;
		if (got !== want) begin
			errorCnt++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	// one sliced line with random flags, number and body bytes
	task automatic sendLine(input logic b, input logic s, input int n);
		logic [8:0] ln;
		logic [4:0] f;
		logic [7:0] pb;
		ln = 9'($random(seed));
		f  = 5'($random(seed));
		@(posedge core_clk);
		lineStart <= 1'b1;
		lineNum   <= ln;
		fmtBasic  <= b;
		sys625    <= s;
		{hamErr, parErr, hdrErr, match2, match1} <= f;
		expQ.push_back(ln[7:0]);
		expQ.push_back({2'b00, f[4:3], f[2] & b, f[1:0], ln[8]});
		@(posedge core_clk);
		lineStart <= 1'b0;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			pb = 8'($random(seed));
			payloadValid <= 1'b1;
			payloadByte  <= pb;
			if (i + 2 < recLen(b, s)) expQ.push_back(pb);
			@(posedge core_clk);
		end
		payloadValid <= 1'b0;
		lineEnd      <= 1'b1;
		@(posedge core_clk);
		lineEnd <= 1'b0;
		@(posedge core_clk);
	endtask

	// read back every queued byte with no gap; a further read finds the queue empty
	task automatic readRec;
		logic [7:0] d;
		while (expQ.size() > 0) begin
			i_host.rdHeld(HP_QUEUE, d);
			cmp(d, expQ.pop_front());
		end
		i_host.rd(HP_QUEUE, d);
		cmp(d, 8'h00);
	endtask

	// one-cycle event on the caption strobe or the field end
	task automatic pulse(input bit cc);
		@(posedge core_clk);
		if (cc) ccValid <= 1'b1;
		else fieldEnd <= 1'b1;
		@(posedge core_clk);
		ccValid  <= 1'b0;
		fieldEnd <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic wrapUp;
		$display("checks %0d errors %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#500000;
		errorCnt++;
		wrapUp();
	end

	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] c0;
		logic [7:0] c1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		i_host.rd(HP_STATUS, d);
		cmp(d, 8'h00);
		i_host.wr(HP_INDEX, IX_CTRL);
		i_host.rd(HP_DATA, d);
		cmp(d, 8'h01);
		i_host.wr(HP_INDEX, 8'h04);
		i_host.rd(HP_DATA, d);
		cmp(d, 8'h00);
		i_host.wr(HP_INDEX, IX_MASK);
		i_host.wr(HP_DATA, 8'h01);
		// every format, each with one or more surplus body bytes
		for (int k = 0; k < 3; k++) begin
			sendLine(k == 0, k == 2, recLen(k == 0, k == 2) - 1 + k);
			#1 cmp({7'h00, irq}, 8'h01);
			i_host.rd(HP_STATUS, d);
			cmp(d, 8'h01);
			i_host.wr(HP_STATUS, 8'h01);
			readRec();
			i_host.rd(HP_STATUS, d);
			cmp(d, 8'h00);
			cmp({7'h00, irq}, 8'h00);
		end
		// field end while masked, then unmasked
		pulse(1'b0);
		i_host.rd(HP_STATUS, d);
		cmp(d, 8'h02);
		cmp({7'h00, irq}, 8'h00);
		i_host.wr(HP_DATA, 8'h02);
		repeat (2) @(posedge core_clk);
		#1 cmp({7'h00, irq}, 8'h01);
		i_host.wr(HP_STATUS, 8'h02);
		// caption pair kept apart from the queue; lines refused while teletext is off
		i_host.wr(HP_INDEX, IX_CTRL);
		i_host.wr(HP_DATA, 8'h02);
		c0 = 8'($random(seed));
		c1 = 8'($random(seed));
		ccByte0 <= c0;
		ccByte1 <= c1;
		pulse(1'b1);
		i_host.wr(HP_INDEX, IX_CC_LO);
		i_host.rd(HP_DATA, d);
		cmp(d, c0);
		i_host.wr(HP_INDEX, IX_CC_HI);
		i_host.rd(HP_DATA, d);
		cmp(d, c1);
		sendLine(1'b1, 1'b0, 33);
		expQ.delete();
		i_host.rd(HP_STATUS, d);
		cmp(d, 8'h08);
		i_host.rd(HP_QUEUE, d);
		cmp(d, 8'h00);
		// ancillary output, pad never sent
		i_host.wr(HP_INDEX, IX_CTRL);
		i_host.wr(HP_DATA, 8'h05);
		sendLine(1'b1, 1'b0, 33);
		for (int w = 0; w < 500 && ancQ.size() < 35; w++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
		cmp(8'(ancQ.size()), 8'd35);
		while (expQ.size() > 0 && ancQ.size() > 0) cmp(ancQ.pop_front(), expQ.pop_front());
		i_host.rd(HP_QUEUE, d);
		cmp(d, 8'h00);
		// capacity: the last fitting record is kept, the next one dropped
		for (int k = 0; k < 2; k++) begin
			reset <= 1'b1;
			@(posedge core_clk);
			reset <= 1'b0;
			for (int j = 0; j < (k ? 12 : 15); j++) begin
				sendLine(k == 0, 1'b1, k ? 42 : 33);
				i_host.rd(HP_STATUS, d);
				cmp({7'h00, d[ST_OVF]}, {7'h00, j == (k ? 11 : 14)});
			end
			// drop the refused line's bytes, then drain the kept records, across the pads of the basic ones
			repeat (k ? 44 : 35) expQ.delete(expQ.size() - 1);
			readRec();
		end
		wrapUp();
	end
endmodule
